// ==== flash_status_defs.vh ====
`ifndef FLASH_STATUS_DEFS_VH
`define FLASH_STATUS_DEFS_VH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define OPC_STATUS_READ      8'h05
`define OPC_STATUS2_READ_A   8'h09
`define OPC_STATUS2_READ_B   8'h35
`define OPC_STATUS_WRITE     8'h01
`define OPC_STATUS2_WRITE    8'h31
`define OPC_LATCH_SET        8'h06
`define OPC_LATCH_CLEAR      8'h04
`define OPC_VOLATILE_EN      8'h50
`define OPC_QUAD_ENTER       8'h38
`define OPC_QUAD_EXIT        8'hff
`define OPC_PAGE_WRITE       8'h02
`define OPC_QUAD_PAGE_WRITE  8'h32
`define OPC_WIPE_4K          8'h20
`define OPC_HALF_BLOCK_WIPE  8'h52
`define OPC_BLOCK_WIPE       8'hd8
`define OPC_CHIP_WIPE_A      8'hc7
`define OPC_CHIP_WIPE_B      8'h60

// ----------------------------------------------------------------------
// Engine operation kinds
// ----------------------------------------------------------------------
`define OP_PAGE              3'h0
`define OP_QUAD_PAGE         3'h1
`define OP_WIPE_4K           3'h2
`define OP_HALF_BLOCK        3'h3
`define OP_BLOCK             3'h4
`define OP_CHIP              3'h5

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SR1_LOCK_BIT         5
`define SR1_TB_BIT           4
`define SR1_LEVEL_MSB        3
`define SR2_CMP_BIT          6
`define SR2_OTP0_BIT         5
`define SR2_OTP1_BIT         4
`define SR2_OTP2_BIT         3
`define SR2_QE_BIT           1
`define NV_SR_RESET          6'h00
`define NV_CMP_RESET         1'h0
`define NV_QE_RESET          1'h1
`define VOL_RESET            6'h00

// ----------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------
`define ADDR_BITS            24
`define ADDR_BYTES           2'h3
`define LOG_UNIT             16
`define CORE_PERIOD_NS       5
`define SR_WRITE_NS          10000
`define SW_CNT_W             16

`endif

// ==== pin_sync.v ====
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         core_clk,
	input  wire         rst_b,
	// Pin side and synchronised side
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// Two flops in series, the first read only by the second
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= {W{1'b1}};
			sync_q <= {W{1'b1}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule // pin_sync

`default_nettype wire

// ==== region_guard.v ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_defs.vh"

module region_guard #(
	parameter ADDR_W   = `ADDR_BITS,
	parameter LOG_UNIT = `LOG_UNIT
) (
	// Protection fields
	input  wire [3:0]        level,
	input  wire              top_bottom_select,
	input  wire              protect_invert,
	// Target address and verdicts
	input  wire [ADDR_W-1:0] addr,
	output reg               addr_locked,
	output reg               chip_free
);

	integer i;
	integer edge_bit;
	reg     all_one;
	reg     all_zero;
	reg     in_region;

	// Region is the top or bottom span of 2^(LOG_UNIT+level-1) bytes
	always @* begin
		edge_bit = LOG_UNIT + level - 1;
		all_one  = 1'b1;
		all_zero = 1'b1;
		for (i = 0; i < ADDR_W; i = i + 1) begin
			if (i >= edge_bit) begin
				all_one  = all_one & addr[i];
				all_zero = all_zero & ~addr[i];
			end
		end
		in_region = (level != 4'h0) &&
			(top_bottom_select ? all_zero : all_one);
		addr_locked = protect_invert ? ~in_region : in_region;
		// Whole wipe only when nothing at all is covered
		if (protect_invert) begin
			chip_free = (level != 4'h0) && (edge_bit >= ADDR_W);
		end else begin
			chip_free = (level == 4'h0);
		end
	end

endmodule // region_guard

`default_nettype wire

// ==== flash_status_protect_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_defs.vh"

module flash_status_protect_regs #(
	parameter ADDR_W      = `ADDR_BITS,
	parameter SR_WRITE_NS = `SR_WRITE_NS
) (
	// Clock and reset
	input  wire              core_clk,
	input  wire              rst_b,
	// Serial pins
	input  wire              sclk,
	input  wire              cs_b,
	input  wire              wp_b,
	input  wire [3:0]        dq_in,
	output wire [3:0]        dq_out,
	output wire [3:0]        dq_oe_b,
	// Engine events
	input  wire              erase_suspend,
	input  wire              erase_resume,
	input  wire              program_suspend,
	input  wire              program_resume,
	input  wire              op_done,
	// Engine requests
	output wire              op_start,
	output wire [2:0]        op_kind,
	output wire [ADDR_W-1:0] op_addr,
	output wire [7:0]        prog_data,
	output wire              prog_data_valid,
	// Mode outputs
	output wire [2:0]        otp_lock,
	output wire              quad_io_select,
	output wire              quad_command_mode
);

	// ------------------------------------------------------------------
	// Frame phases
	// ------------------------------------------------------------------
	localparam PH_OPC  = 3'h0;
	localparam PH_ADDR = 3'h1;
	localparam PH_DATA = 3'h2;
	localparam PH_READ = 3'h3;
	localparam PH_SKIP = 3'h4;
	localparam [`SW_CNT_W-1:0] SW_CYC =
		(SR_WRITE_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS;

	// ------------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ------------------------------------------------------------------
	wire [6:0] pins_s;
	wire       sclk_s;
	wire       cs_s;
	wire       wp_s;
	wire [3:0] dq_s;
	reg        sclk_prev_q;
	reg        cs_prev_q;

	pin_sync #(
		.W (7)
	) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.async_in ({sclk, cs_b, wp_b, dq_in}),
		.sync_out (pins_s)
	);

	assign sclk_s = pins_s[6];
	assign cs_s   = pins_s[5];
	assign wp_s   = pins_s[4];
	assign dq_s   = pins_s[3:0];

	// Previous levels for edge detection
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_prev_q <= 1'b1;
			cs_prev_q   <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			cs_prev_q   <= cs_s;
		end
	end

	wire sclk_rise = sclk_s & ~sclk_prev_q;
	wire sclk_fall = ~sclk_s & sclk_prev_q;
	wire cs_fall   = ~cs_s & cs_prev_q;
	wire cs_rise   = cs_s & ~cs_prev_q;

	// ------------------------------------------------------------------
	// Status state
	// ------------------------------------------------------------------
	reg                 busy_eng_q;
	reg [`SW_CNT_W-1:0] sw_cnt_q;
	reg                 wel_q;
	reg                 vol_en_q;
	reg                 vol_act_q;
	reg [5:0]           vol_sr_q;
	reg [5:0]           nv_sr_q;
	reg                 cmp_q;
	reg [2:0]           otp_q;
	reg                 qe_q;
	reg                 quad_q;
	reg                 erase_paused_q;
	reg                 program_paused_q;
	reg                 op_start_q;
	reg [2:0]           op_kind_q;
	reg [ADDR_W-1:0]    op_addr_q;

	// Effective protection fields: volatile copy if it was written since the last non-volatile write
	wire [5:0] eff_sr  = vol_act_q ? vol_sr_q : nv_sr_q;
	wire       busy    = busy_eng_q | (sw_cnt_q != {`SW_CNT_W{1'b0}});
	wire [7:0] sr1     = {eff_sr, wel_q, busy};
	wire [7:0] sr2     = {erase_paused_q, cmp_q, otp_q[0], otp_q[1],
		otp_q[2], program_paused_q, qe_q, 1'b0};
	// Write-protect pin only counts while the quad enable bit is clear
	wire       hw_prot = eff_sr[`SR1_LOCK_BIT] & ~wp_s & ~qe_q;

	// ------------------------------------------------------------------
	// Frame capture and readout
	// ------------------------------------------------------------------
	reg [2:0]        phase_q;
	reg [7:0]        rx_q;
	reg [2:0]        bit_cnt_q;
	reg [7:0]        opc_q;
	reg [1:0]        byte_cnt_q;
	reg [1:0]        data_cnt_q;
	reg [7:0]        wr0_q;
	reg [7:0]        wr1_q;
	reg [ADDR_W-1:0] addr_q;
	reg              sel2_q;
	reg [7:0]        tx_q;
	reg [2:0]        tx_cnt_q;
	reg [3:0]        dq_out_q;
	reg [3:0]        dq_oe_b_q;
	reg [7:0]        prog_data_q;
	reg              prog_data_valid_q;

	wire [2:0] step    = quad_q ? 3'h4 : 3'h1;
	wire [7:0] rx_next = quad_q ? {rx_q[3:0], dq_s} : {rx_q[6:0], dq_s[0]};
	wire [2:0] bit_nxt = bit_cnt_q + step;
	wire [7:0] live    = sel2_q ? sr2 : sr1;
	wire [7:0] tx_byte = (tx_cnt_q == 3'h0) ? live : tx_q;
	wire       is_swr  = (opc_q == `OPC_STATUS_WRITE) ||
		(opc_q == `OPC_STATUS2_WRITE);

	// Shift in on rising edge, shift out on falling edge
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_q           <= PH_OPC;
			rx_q              <= 8'h00;
			bit_cnt_q         <= 3'h0;
			opc_q             <= 8'h00;
			byte_cnt_q        <= 2'h0;
			data_cnt_q        <= 2'h0;
			wr0_q             <= 8'h00;
			wr1_q             <= 8'h00;
			addr_q            <= {ADDR_W{1'b0}};
			sel2_q            <= 1'b0;
			tx_q              <= 8'h00;
			tx_cnt_q          <= 3'h0;
			dq_out_q          <= 4'h0;
			dq_oe_b_q         <= 4'hf;
			prog_data_q       <= 8'h00;
			prog_data_valid_q <= 1'b0;
		end else begin
			prog_data_valid_q <= 1'b0;
			if (cs_s) begin
				dq_oe_b_q <= 4'hf;
			end
			if (cs_fall) begin
				phase_q    <= PH_OPC;
				bit_cnt_q  <= 3'h0;
				byte_cnt_q <= 2'h0;
				data_cnt_q <= 2'h0;
				tx_cnt_q   <= 3'h0;
			end else if (!cs_s) begin
				if (sclk_rise && phase_q != PH_READ && phase_q != PH_SKIP) begin
					rx_q      <= rx_next;
					bit_cnt_q <= bit_nxt;
					if (bit_nxt == 3'h0) begin
						case (phase_q)
						PH_OPC: begin
							opc_q <= rx_next;
							if (rx_next == `OPC_STATUS_READ) begin
								phase_q <= PH_READ;
								sel2_q  <= 1'b0;
							end else if (rx_next == `OPC_STATUS2_READ_A ||
								rx_next == `OPC_STATUS2_READ_B) begin
								phase_q <= PH_READ;
								sel2_q  <= 1'b1;
							end else if (rx_next == `OPC_STATUS_WRITE ||
								rx_next == `OPC_STATUS2_WRITE) begin
								phase_q <= PH_DATA;
							end else if (rx_next == `OPC_PAGE_WRITE ||
								rx_next == `OPC_WIPE_4K ||
								rx_next == `OPC_HALF_BLOCK_WIPE ||
								rx_next == `OPC_BLOCK_WIPE ||
								(rx_next == `OPC_QUAD_PAGE_WRITE &&
								!quad_q)) begin
								phase_q <= PH_ADDR;
							end else begin
								phase_q <= PH_SKIP;
							end
						end
						PH_ADDR: begin
							addr_q <= {addr_q[ADDR_W-9:0], rx_next};
							byte_cnt_q <= byte_cnt_q + 2'h1;
							if (byte_cnt_q == `ADDR_BYTES - 2'h1) begin
								phase_q <= PH_DATA;
							end
						end
						PH_DATA: begin
							if (data_cnt_q != 2'h3) begin
								data_cnt_q <= data_cnt_q + 2'h1;
							end
							if (is_swr && data_cnt_q == 2'h0) begin
								wr0_q <= rx_next;
							end
							if (is_swr && data_cnt_q == 2'h1) begin
								wr1_q <= rx_next;
							end
							if (!is_swr) begin
								prog_data_q       <= rx_next;
								prog_data_valid_q <= 1'b1;
							end
						end
						default: begin
							phase_q <= PH_SKIP;
						end
						endcase
					end
				end
				// Readout reloads the live byte at each byte boundary
				if (sclk_fall && phase_q == PH_READ) begin
					tx_cnt_q <= tx_cnt_q + step;
					if (quad_q) begin
						dq_out_q  <= tx_byte[7:4];
						dq_oe_b_q <= 4'h0;
						tx_q      <= {tx_byte[3:0], 4'h0};
					end else begin
						dq_out_q  <= {2'h0, tx_byte[7], 1'b0};
						dq_oe_b_q <= 4'hd;
						tx_q      <= {tx_byte[6:0], 1'b0};
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Protection decode
	// ------------------------------------------------------------------
	wire addr_locked;
	wire chip_free;

	region_guard #(
		.ADDR_W   (ADDR_W),
		.LOG_UNIT (`LOG_UNIT)
	) u_guard (
		.level             (eff_sr[`SR1_LEVEL_MSB:0]),
		.top_bottom_select (eff_sr[`SR1_TB_BIT]),
		.protect_invert    (cmp_q),
		.addr              (addr_q),
		.addr_locked       (addr_locked),
		.chip_free         (chip_free)
	);

	// ------------------------------------------------------------------
	// Command execution at end of frame
	// ------------------------------------------------------------------
	wire frame_ok  = (bit_cnt_q == 3'h0);
	wire addr_full = (phase_q == PH_DATA) && !is_swr;
	wire pe_ok     = wel_q && addr_full && !addr_locked;
	wire wipe_ok   = pe_ok && (data_cnt_q == 2'h0);
	wire prog_ok   = pe_ok && (data_cnt_q != 2'h0);

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_eng_q       <= 1'b0;
			sw_cnt_q         <= {`SW_CNT_W{1'b0}};
			wel_q            <= 1'b0;
			vol_en_q         <= 1'b0;
			vol_act_q        <= 1'b0;
			vol_sr_q         <= `VOL_RESET;
			nv_sr_q          <= `NV_SR_RESET;
			cmp_q            <= `NV_CMP_RESET;
			otp_q            <= 3'h0;
			qe_q             <= `NV_QE_RESET;
			quad_q           <= 1'b0;
			erase_paused_q   <= 1'b0;
			program_paused_q <= 1'b0;
			op_start_q       <= 1'b0;
			op_kind_q        <= `OP_PAGE;
			op_addr_q        <= {ADDR_W{1'b0}};
		end else begin
			op_start_q <= 1'b0;
			// Engine completion clears busy and the latch
			if (op_done) begin
				busy_eng_q <= 1'b0;
				wel_q      <= 1'b0;
			end
			// Self-timed status write cycle
			if (sw_cnt_q != {`SW_CNT_W{1'b0}}) begin
				sw_cnt_q <= sw_cnt_q - {{(`SW_CNT_W-1){1'b0}}, 1'b1};
				if (sw_cnt_q == {{(`SW_CNT_W-1){1'b0}}, 1'b1}) begin
					wel_q <= 1'b0;
				end
			end
			// Suspend flags, set wins over clear
			if (erase_suspend) begin
				erase_paused_q <= 1'b1;
			end else if (erase_resume) begin
				erase_paused_q <= 1'b0;
			end
			if (program_suspend) begin
				program_paused_q <= 1'b1;
			end else if (program_resume) begin
				program_paused_q <= 1'b0;
			end
			if (cs_rise && frame_ok && !busy) begin
				vol_en_q <= 1'b0;
				case (opc_q)
				`OPC_LATCH_SET: begin
					wel_q <= 1'b1;
				end
				`OPC_LATCH_CLEAR: begin
					wel_q <= 1'b0;
				end
				`OPC_VOLATILE_EN: begin
					vol_en_q <= 1'b1;
				end
				`OPC_STATUS_WRITE: begin
					if (data_cnt_q != 2'h0 && !hw_prot) begin
						if (vol_en_q) begin
							vol_sr_q  <= wr0_q[7:2];
							vol_act_q <= 1'b1;
						end else if (wel_q) begin
							nv_sr_q   <= wr0_q[7:2];
							vol_act_q <= 1'b0;
							sw_cnt_q  <= SW_CYC;
							if (data_cnt_q != 2'h1) begin
								cmp_q <= wr1_q[`SR2_CMP_BIT];
								otp_q <= otp_q | {wr1_q[`SR2_OTP2_BIT],
									wr1_q[`SR2_OTP1_BIT],
									wr1_q[`SR2_OTP0_BIT]};
								qe_q  <= wr1_q[`SR2_QE_BIT];
							end
						end
					end
				end
				`OPC_STATUS2_WRITE: begin
					if (data_cnt_q != 2'h0 && wel_q && !hw_prot) begin
						cmp_q    <= wr0_q[`SR2_CMP_BIT];
						otp_q    <= otp_q | {wr0_q[`SR2_OTP2_BIT],
							wr0_q[`SR2_OTP1_BIT],
							wr0_q[`SR2_OTP0_BIT]};
						qe_q     <= wr0_q[`SR2_QE_BIT];
						sw_cnt_q <= SW_CYC;
					end
				end
				`OPC_QUAD_ENTER: begin
					if (qe_q) begin
						quad_q <= 1'b1;
					end
				end
				`OPC_QUAD_EXIT: begin
					quad_q <= 1'b0;
				end
				`OPC_PAGE_WRITE, `OPC_QUAD_PAGE_WRITE: begin
					if (prog_ok) begin
						op_start_q <= 1'b1;
						busy_eng_q <= 1'b1;
						op_addr_q  <= addr_q;
						op_kind_q  <= (opc_q == `OPC_PAGE_WRITE) ?
							`OP_PAGE : `OP_QUAD_PAGE;
					end
				end
				`OPC_WIPE_4K, `OPC_HALF_BLOCK_WIPE, `OPC_BLOCK_WIPE: begin
					if (wipe_ok) begin
						op_start_q <= 1'b1;
						busy_eng_q <= 1'b1;
						op_addr_q  <= addr_q;
						op_kind_q  <= (opc_q == `OPC_WIPE_4K) ? `OP_WIPE_4K :
							(opc_q == `OPC_BLOCK_WIPE) ? `OP_BLOCK :
							`OP_HALF_BLOCK;
					end
				end
				`OPC_CHIP_WIPE_A, `OPC_CHIP_WIPE_B: begin
					if (wel_q && chip_free) begin
						op_start_q <= 1'b1;
						busy_eng_q <= 1'b1;
						op_kind_q  <= `OP_CHIP;
					end
				end
				default: begin
					vol_en_q <= 1'b0;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign dq_out            = dq_out_q;
	assign dq_oe_b           = dq_oe_b_q;
	assign op_start          = op_start_q;
	assign op_kind           = op_kind_q;
	assign op_addr           = op_addr_q;
	assign prog_data         = prog_data_q;
	assign prog_data_valid   = prog_data_valid_q;
	assign otp_lock          = otp_q;
	assign quad_io_select    = qe_q;
	assign quad_command_mode = quad_q;

endmodule // flash_status_protect_regs

`default_nettype wire

// ==== pin_sync_note_unused.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== flash_status_protect_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

// --------
// Port checker
// --------
module flash_status_protect_regs_checker (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst_b,
	// Serial side
	input wire logic       cs_b,
	input wire logic [3:0] dq_oe_b,
	// Engine and mode side
	input wire logic       op_start,
	input wire logic [2:0] op_kind,
	input wire logic [2:0] otp_lock,
	input wire logic       quad_io_select,
	input wire logic       quad_command_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Pins released between frames, lanes fixed by mode
	a_idle_pins_off: assert property (
		cs_b [*8] |-> dq_oe_b == 4'hf)
		else $error("Data pins driven outside a frame");
	a_single_lane: assert property (
		!quad_command_mode && dq_oe_b != 4'hf |-> dq_oe_b == 4'hd)
		else $error("Single mode readout on wrong pins");
	a_quad_lanes: assert property (
		quad_command_mode && dq_oe_b != 4'hf |-> dq_oe_b == 4'h0)
		else $error("Quad mode readout on wrong pins");

	// Lock bits only ever set, settings only change between frames
	a_otp_only_sets: assert property (
		(otp_lock & $past(otp_lock)) == $past(otp_lock))
		else $error("One-time lock bit cleared");
	a_regs_hold_frame: assert property (
		!cs_b |=> $stable({otp_lock, quad_io_select}))
		else $error("Settings changed inside a frame");
	a_quad_needs_qe: assert property (
		$rose(quad_command_mode) |-> quad_io_select)
		else $error("Quad command mode entered with quad pins off");

	// Engine starts only after a frame ends, one at a time
	a_start_after_cs: assert property (
		op_start |-> cs_b && op_kind <= 3'h5)
		else $error("Engine start inside a frame or bad kind");
	a_start_single: assert property (
		op_start |=> !op_start [*8])
		else $error("Engine start repeated");
endmodule // flash_status_protect_regs_checker

bind flash_status_protect_regs flash_status_protect_regs_checker chk_i (
	.core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b), .dq_oe_b(dq_oe_b),
	.op_start(op_start), .op_kind(op_kind), .otp_lock(otp_lock),
	.quad_io_select(quad_io_select),
	.quad_command_mode(quad_command_mode));

`default_nettype wire

// ==== flash_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// --------
// Serial host, mode 0, clock parked between frames
// --------
module flash_host_model (
	// Serial pins
	output logic            sclk,
	output logic            cs_b,
	output logic [3:0]      dq_in,
	input  wire logic [3:0] dq_out,
	// Lane mode
	input  wire logic       quad
);
	// Link idle
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		dq_in = 4'h0;
	end

	// Send nb bytes msb first, gather bits after the opcode
	task automatic frame(input int nb, input logic [47:0] tx,
		output logic [15:0] rx);
		int s;
		s = quad ? 4 : 1;
		rx = 16'h0;
		cs_b = 1'b0;
		for (int i = 47; i > 47 - 8 * nb; i -= s) begin
			dq_in = quad ? tx[i-:4] : {3'h0, tx[i]};
			#24;
			if (i < 40)
				rx = quad ? {rx[11:0], dq_out} : {rx[14:0], dq_out[1]};
			sclk = 1'b1;
			#24;
			sclk = 1'b0;
		end
		#24;
		cs_b = 1'b1;
		dq_in = ~dq_in; // Released lines show no stale value
		#120;
	endtask
endmodule // flash_host_model

`default_nettype wire

// ==== flash_status_protect_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module flash_status_protect_regs_tb;
	logic        core_clk;
	logic        rst_b;
	logic        wp_b;
	logic        quad;
	logic [4:0]  ev;
	logic [15:0] rx;
	wire         sclk;
	wire         cs_b;
	wire  [3:0]  dq_in;
	wire  [3:0]  dq_out;
	wire  [3:0]  dq_oe_b;
	wire         op_start;
	wire  [2:0]  op_kind;
	wire  [23:0] op_addr;
	wire  [7:0]  prog_data;
	wire         prog_data_valid;
	wire  [2:0]  otp_lock;
	wire         quad_io_select;
	wire         quad_command_mode;
	int          fails;
	int          total_checks;
	int          cyc;
	int          starts;
	int          pdv;
	logic [47:0] deny [6] = '{{16'h0200, 32'h0100a5}, {16'h3200, 32'h0100a5},
		{16'h2000, 32'h1000}, {16'h5200, 32'h0}, {16'hd800, 32'h0}, 48'hc7 << 40};
	int          deny_n [6] = '{5, 5, 4, 4, 4, 1};

	flash_status_protect_regs #(.SR_WRITE_NS(5000)) DUT (
		.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
		.wp_b(wp_b), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_b(dq_oe_b),
		.erase_suspend(ev[0]), .erase_resume(ev[1]),
		.program_suspend(ev[2]), .program_resume(ev[3]), .op_done(ev[4]),
		.op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
		.prog_data(prog_data), .prog_data_valid(prog_data_valid),
		.otp_lock(otp_lock),
		.quad_io_select(quad_io_select),
		.quad_command_mode(quad_command_mode));
	flash_host_model host (.sclk(sclk), .cs_b(cs_b), .dq_in(dq_in),
		.dq_out(dq_out), .quad(quad));

	// Core clock
	always #2.5 core_clk = ~core_clk;

	// Cycle ceiling, engine start count and data strobe count
	always @(posedge core_clk) begin
		cyc++;
		if (op_start === 1'b1)
			starts++;
		if (prog_data_valid === 1'b1)
			pdv++;
		if (cyc == 40000) begin
			fails++;
			conclude();
		end
	end

	// --------
	// Access tasks
	// --------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t ns got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic f(input int nb, input logic [47:0] tx);
		host.frame(nb, tx, rx);
	endtask

	task automatic op1(input logic [7:0] o);
		f(1, {o, 40'h0});
	endtask

	// Read twice in one frame, both copies compared
	task automatic rd(input logic [7:0] o, input logic [7:0] exp);
		f(3, {o, 40'h0});
		chk(rx, {exp, exp});
	endtask

	task automatic poll();
		rx = 16'h1;
		for (int n = 0; n < 40 && rx[0] !== 1'b0; n++)
			f(2, {8'h05, 40'h0});
		chk(rx[0], 1'b0);
	endtask

	task automatic wr(input logic [15:0] cmd);
		op1(8'h06);
		f(2, {cmd, 32'h0});
		poll();
	endtask

	task automatic pulse(input int k);
		@(negedge core_clk);
		ev[k] = 1'b1;
		@(negedge core_clk);
		ev[k] = 1'b0;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// --------
	// Main sequence
	// --------
	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		wp_b = 1'b1;
		quad = 1'b0;
		ev = 5'h0;
		repeat (16) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (8) @(negedge core_clk);
		rd(8'h05, 8'h00);
		rd(8'h35, 8'h02);
		rd(8'h09, 8'h02);
		f(2, {16'h013c, 32'h0});
		rd(8'h05, 8'h00);
		op1(8'h06);
		rd(8'h05, 8'h02);
		f(2, {16'h017c, 32'h0});
		rd(8'h05, 8'h7f);
		poll();
		rd(8'h05, 8'h7c);
		for (int k = 0; k < 6; k++) begin
			op1(8'h06);
			f(deny_n[k], deny[k]);
		end
		chk(starts, 0);
		wr(16'h0100);
		op1(8'h06);
		op1(8'hc7);
		chk(starts, 1);
		chk(op_kind, 3'h5);
		rd(8'h05, 8'h03);
		pulse(4);
		rd(8'h05, 8'h00);
		// Top span locked: top address refused, low address programmed
		wr(16'h0104);
		op1(8'h06);
		f(5, {8'h02, 24'hff0000, 16'h5a00});
		op1(8'h06);
		f(5, {8'h02, 24'h000010, 16'h5a00});
		chk(starts, 2);
		chk(op_addr, 24'h000010);
		chk(prog_data, 8'h5a);
		chk(op_kind, 3'h0);
		chk(pdv, 4);
		rd(8'h05, 8'h07);
		pulse(4);
		f(5, {8'h02, 24'h000010, 16'h5a00});
		chk(starts, 2);
		// Bottom span selected, then inverted by the complement bit
		wr(16'h0144);
		op1(8'h06);
		f(5, {8'h02, 24'h000010, 16'h5a00});
		chk(starts, 2);
		wr(16'h3142);
		op1(8'h06);
		f(5, {8'h02, 24'hff0000, 16'h5a00});
		op1(8'h06);
		f(5, {8'h02, 24'h000010, 16'h5a00});
		chk(starts, 3);
		pulse(4);
		wr(16'h3100);
		rd(8'h35, 8'h00);
		wr(16'h0180);
		@(negedge core_clk);
		wp_b = 1'b0;
		op1(8'h06);
		f(2, {16'h0104, 32'h0});
		op1(8'h04);
		rd(8'h05, 8'h80);
		@(negedge core_clk);
		wp_b = 1'b1;
		wr(16'h0100);
		wr(16'h3122);
		wr(16'h3102);
		chk(otp_lock, 3'h1);
		rd(8'h35, 8'h22);
		pulse(0);
		pulse(2);
		rd(8'h35, 8'ha6);
		pulse(1);
		pulse(3);
		rd(8'h35, 8'h22);
		op1(8'h50);
		f(2, {16'h013c, 32'h0});
		rd(8'h05, 8'h3c);
		op1(8'h38);
		quad = 1'b1;
		chk(quad_command_mode, 1'b1);
		rd(8'h35, 8'h22);
		op1(8'hff);
		quad = 1'b0;
		@(negedge core_clk);
		rst_b = 1'b0;
		repeat (16) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (8) @(negedge core_clk);
		rd(8'h05, 8'h00);
		chk({otp_lock, quad_io_select}, 4'h1);
		conclude();
	end
endmodule // flash_status_protect_regs_tb

`default_nettype wire
